/* rdsc_bus_model.sv */
// Two-wire bus with pull-ups and a rival party that can hold lines low.
// Assumes open-drain enables from the block, high meaning pull low.
`timescale 1ns/10ps
`default_nettype none
module rdsc_bus_model (
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic pull_scl,
  input wire logic pull_sda,
  output logic scl,
  output logic sda
);
  // ---------
  // Wired lines
  // ---------
  assign scl = !(scl_oe || pull_scl);
  assign sda = !(sda_oe || pull_sda);
endmodule
`default_nettype wire

/* rdsc_counter.sv */
// Rate divider down-counter: loads, counts to zero on phase ticks, holds.
// Assumes tick and load are single-cycle pulses in the clock domain.
`timescale 1ns/10ps
`default_nettype none
module rdsc_counter
  import rdsc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic clear,
  input wire logic tick,
  input wire logic [6:0] reload,
  output logic [6:0] count,
  output logic expired
);

  logic [6:0] count_ff;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= RDSC_COUNT_RST;
    end else if (clk_en) begin
      if (clear) begin
        count_ff <= RDSC_COUNT_RST;
      end else if (load) begin
        count_ff <= reload;
      end else if (tick && count_ff != 7'h00) begin
        count_ff <= count_ff - 7'h01;
      end
    end
  end

  assign count = count_ff;
  // Expiry seen on the tick that finds the counter at zero; kept free of load and
  // clear so that a reload driven from expiry does not form a combinational loop
  assign expired = tick && (count_ff == 7'h00);

endmodule
`default_nettype wire

/* rdsc_master.sv */
// Two-wire master serial-clock rate generator and START collision logic.
// Assumes pins are synchronous, phase ticks and bus events come from the port.
//
// What this block does
// - Reload value is the low seven bits of the address reload register.
// - In master mode, writing the transfer buffer starts the rate divider counter.
// - Counter counts down to zero then holds until reloaded.
// - Counter decrements on second and fourth quarter-phase ticks.
// - As master the counter reloads itself with no software help.
// - After last bit and acknowledge, counting stops, clock line holds.
// - One clock period spans two counter rollovers.
// - Data or clock low at START begin flags a collision.
// - Clock low before data driven low during START is a collision.
// - Collision aborts START, sets flag, returns port unit to idle.
// - START begins released; data high loads counter and counts to zero.
// - Clock low while data high in first count is a collision.
// - Data low in first count resets counter, drives data low early.
// - Data high through first count drives data low at expiry.
// - Second count after data low ignores a low clock line.
// - Second count expiry drives clock low, completing START.
// - Rival masters at START are no collision; they arbitrate later.
`timescale 1ns/10ps
`default_nettype none
module rdsc_master
  import rdsc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic master_mode,
  input wire logic [7:0] address_reload_register,
  input wire logic transfer_buffer_write,
  input wire logic start_request,
  input wire logic operation_done,
  input wire logic second_quarter_phase_tick,
  input wire logic fourth_quarter_phase_tick,
  input wire logic bus_collision_flag_clear,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  output logic start_done,
  output logic counting,
  output logic [6:0] rate_divider_counter,
  output logic bus_collision_flag,
  output logic attention_request,
  output logic busy
);

  rdsc_state_t state_ff;
  rdsc_state_t nxt_state;
  rdsc_bus_t drive_low_ff;
  rdsc_bus_t nxt_drive_low;
  logic run_ff;
  logic nxt_run;
  logic done_ff;
  logic nxt_done;
  logic flag_ff;
  logic collision;
  logic tick;
  logic load;
  logic clear;
  logic expired;
  logic [6:0] reload;
  logic [6:0] count;
  logic hold_reload_ff;

  // ---------------------------------------------------------------
  // Counter control
  // ---------------------------------------------------------------
  assign reload = address_reload_register[6:0];
  assign tick = second_quarter_phase_tick || fourth_quarter_phase_tick;

  rdsc_counter u_counter (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .load(load),
    .clear(clear),
    .tick(tick),
    .reload(reload),
    .count(count),
    .expired(expired)
  );

  // ---------------------------------------------------------------
  // START sequencing and collision detection
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_drive_low = drive_low_ff;
    nxt_run = run_ff;
    nxt_done = 1'b0;
    load = 1'b0;
    clear = 1'b0;
    collision = 1'b0;
    case (state_ff)
      RDSC_IDLE: begin
        if (master_mode && start_request) begin
          if (!sda_i || !scl_i) begin
            collision = 1'b1;
          end else begin
            nxt_drive_low = '0;
            load = 1'b1;
            nxt_state = RDSC_START_CHECK;
          end
        end else if (master_mode && transfer_buffer_write) begin
          load = 1'b1;
          nxt_run = 1'b1;
          nxt_state = RDSC_RUN;
        end
      end
      RDSC_START_CHECK: begin
        if (!sda_i) begin
          // Another master pulled data first: ours goes low now
          clear = 1'b1;
          nxt_drive_low.sda = 1'b1;
          nxt_state = RDSC_START_HOLD;
        end else if (!scl_i) begin
          collision = 1'b1;
        end else if (expired) begin
          nxt_drive_low.sda = 1'b1;
          nxt_state = RDSC_START_HOLD;
        end
      end
      RDSC_START_HOLD: begin
        // Data is low: reload for the second count; clock low here is tolerated
        load = hold_reload_ff;
        if (expired && !hold_reload_ff) begin
          nxt_drive_low.scl = 1'b1;
          nxt_done = 1'b1;
          nxt_state = RDSC_IDLE;
        end
      end
      RDSC_RUN: begin
        if (operation_done) begin
          nxt_run = 1'b0;
          nxt_state = RDSC_IDLE;
        end else if (expired) begin
          load = 1'b1;
          nxt_drive_low.scl = !drive_low_ff.scl;
        end
      end
      default: begin
        nxt_state = RDSC_IDLE;
      end
    endcase
    if (!master_mode) begin
      nxt_state = RDSC_IDLE;
      nxt_run = 1'b0;
    end
    if (collision) begin
      nxt_state = RDSC_IDLE;
      nxt_drive_low = '0;
      nxt_run = 1'b0;
      clear = 1'b1;
    end
  end

  // Second count reload: happens one cycle after data goes low
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hold_reload_ff <= 1'b0;
    end else if (clk_en) begin
      hold_reload_ff <= (state_ff == RDSC_START_CHECK) && (nxt_state == RDSC_START_HOLD);
    end
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= RDSC_IDLE;
      drive_low_ff <= '0;
      run_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      drive_low_ff <= nxt_drive_low;
      run_ff <= nxt_run;
      done_ff <= nxt_done;
    end
  end

  // ---------------------------------------------------------------
  // Collision flag: set wins over clear
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flag_ff <= 1'b0;
    end else if (clk_en) begin
      if (collision) begin
        flag_ff <= 1'b1;
      end else if (bus_collision_flag_clear) begin
        flag_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = drive_low_ff.scl;
  assign sda_oe = drive_low_ff.sda;
  assign start_done = done_ff;
  assign counting = run_ff || (state_ff != RDSC_IDLE);
  assign rate_divider_counter = count;
  assign bus_collision_flag = flag_ff;
  assign attention_request = flag_ff;
  assign busy = state_ff != RDSC_IDLE;

endmodule
`default_nettype wire

/* rdsc_master_asserts.sv */
// Concurrent checks for the rate generator and START collision block.
// Assumes it is bound to rdsc_master and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module rdsc_master_asserts (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic master_mode,
  input wire logic [7:0] address_reload_register,
  input wire logic transfer_buffer_write,
  input wire logic start_request,
  input wire logic operation_done,
  input wire logic second_quarter_phase_tick,
  input wire logic fourth_quarter_phase_tick,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic start_done,
  input wire logic counting,
  input wire logic [6:0] rate_divider_counter,
  input wire logic bus_collision_flag,
  input wire logic attention_request,
  input wire logic busy
);
  // ---------
  // Properties
  // ---------
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  wire logic go = clk_en && start_request && master_mode && !busy;
  wire logic tick = second_quarter_phase_tick || fourth_quarter_phase_tick;
  property p_attn;
    attention_request == bus_collision_flag;
  endproperty
  a_attn: assert property (p_attn) else $error("attention differs from flag");
  property p_begin_low;
    go && !(scl_i && sda_i) |-> ##[1:3] bus_collision_flag;
  endproperty
  a_begin_low: assert property (p_begin_low) else $error("no collision on low line");
  property p_abort;
    $rose(bus_collision_flag) |-> ##[0:1] (!scl_oe && !sda_oe && !busy);
  endproperty
  a_abort: assert property (p_abort) else $error("collision did not abort");
  property p_dec;
    clk_en && counting && !sda_oe && sda_i && scl_i && tick && rate_divider_counter != 7'h00
      |=> rate_divider_counter == $past(rate_divider_counter) - 7'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("counter did not step down");
  property p_load;
    go && scl_i && sda_i |-> ##[1:2] rate_divider_counter == address_reload_register[6:0];
  endproperty
  a_load: assert property (p_load) else $error("counter not loaded");
  property p_clash;
    clk_en && counting && busy && !sda_oe && !scl_oe && sda_i && !scl_i |-> ##[1:2] bus_collision_flag;
  endproperty
  a_clash: assert property (p_clash) else $error("missed clock clash");
  property p_done;
    start_done |-> scl_oe && sda_oe;
  endproperty
  a_done: assert property (p_done) else $error("start done without lines low");
  property p_stop;
    clk_en && operation_done && counting |=> !counting && $stable(scl_oe);
  endproperty
  a_stop: assert property (p_stop) else $error("counting did not stop");
  property p_run;
    clk_en && transfer_buffer_write && master_mode && !busy |=> counting;
  endproperty
  a_run: assert property (p_run) else $error("write did not start counting");
  property p_reload2;
    $rose(sda_oe) && busy |=> rate_divider_counter == address_reload_register[6:0];
  endproperty
  a_reload2: assert property (p_reload2) else $error("second count not reloaded");
endmodule
bind rdsc_master rdsc_master_asserts chk (.*);
`default_nettype wire

/* rdsc_master_tb.sv */
// Self-checking bench for the rate generator and START collision block.
// Assumes the bus model supplies pin levels; events are scored from a queue.
`timescale 1ns/10ps
`default_nettype none
module rdsc_master_tb;
  import rdsc_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, start_request = 1'b0, transfer_buffer_write = 1'b0;
  logic operation_done = 1'b0, bus_collision_flag_clear = 1'b0, pull_scl = 1'b0, pull_sda = 1'b0;
  logic second_quarter_phase_tick = 1'b0, fourth_quarter_phase_tick = 1'b0, flag_q = 1'b0;
  logic [7:0] address_reload_register = 8'h00;
  logic clk_en = 1'b1, master_mode = 1'b1;
  logic [6:0] held;
  logic [1:0] phase = 2'h0;
  logic scl_i, sda_i, scl_oe, sda_oe, start_done, counting, bus_collision_flag, busy;
  logic [6:0] rate_divider_counter;
  logic [3:0] exp_q[$];
  int num_errors = 0, comparisons = 0, i, n;
  // ---------
  // Clock, ticks, instances
  // ---------
  always #5 clock = ~clock;
  always @(negedge clock) begin
    phase <= phase + 2'h1;
    second_quarter_phase_tick <= (phase == 2'h0);
    fourth_quarter_phase_tick <= (phase == 2'h2);
  end
  rdsc_master uut (.clock, .reset_n, .clk_en, .master_mode, .address_reload_register,
    .transfer_buffer_write, .start_request, .operation_done, .second_quarter_phase_tick,
    .fourth_quarter_phase_tick, .bus_collision_flag_clear, .scl_i, .sda_i, .scl_o(), .scl_oe,
    .sda_o(), .sda_oe, .start_done, .counting, .rate_divider_counter, .bus_collision_flag,
    .attention_request(), .busy);
  rdsc_bus_model partner (.scl_oe, .sda_oe, .pull_scl, .pull_sda, .scl(scl_i), .sda(sda_i));
  // ---------
  // Tasks and scoreboard
  // ---------
  task chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task rst;
    reset_n = 1'b0;
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
  endtask
  task start(input logic [7:0] rl, input logic [3:0] exp);
    @(negedge clock);
    address_reload_register = rl;
    start_request = 1'b1;
    exp_q.push_back(exp);
    @(negedge clock);
    start_request = 1'b0;
  endtask
  task drain;
    for (i = 0; i < 3000 && exp_q.size() != 0; i++) @(negedge clock);
    if (exp_q.size() != 0) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task clr;
    repeat (4) @(negedge clock);
    chk({3'h0, bus_collision_flag}, 4'h1);
    bus_collision_flag_clear = 1'b1;
    @(negedge clock);
    bus_collision_flag_clear = 1'b0;
    chk({3'h0, bus_collision_flag}, 4'h0);
  endtask
  always @(negedge clock) begin
    if (start_done === 1'b1 || (bus_collision_flag === 1'b1 && !flag_q)) begin
      if (exp_q.size() == 0)
        chk(4'hf, 4'h0);
      else
        chk({start_done, bus_collision_flag, scl_oe, sda_oe}, exp_q.pop_front());
    end
    flag_q = bus_collision_flag;
  end
  // ---------
  // Scenarios
  // ---------
  initial begin
    void'($urandom(3226));
    rst();
    for (int k = 0; k < 3; k++) begin
      start(k == 0 ? 8'h80 : k == 1 ? 8'hff : 8'($urandom), 4'hb);
      drain();
      rst();
    end
    pull_scl = 1'b1;
    start(8'h10, 4'h4);
    drain();
    pull_scl = 1'b0;
    clr();
    pull_sda = 1'b1;
    start(8'h10, 4'h4);
    drain();
    pull_sda = 1'b0;
    clr();
    start(8'h20, 4'h4);
    repeat (8) @(negedge clock);
    pull_scl = 1'b1;
    drain();
    pull_scl = 1'b0;
    clr();
    start(8'h7f, 4'hb);
    repeat (8) @(negedge clock);
    pull_sda = 1'b1;
    drain();
    pull_sda = 1'b0;
    rst();
    start(8'h08, 4'hb);
    for (i = 0; i < 600 && sda_oe !== 1'b1; i++) @(negedge clock);
    if (sda_oe !== 1'b1) num_errors++;
    pull_scl = 1'b1;
    drain();
    pull_scl = 1'b0;
    rst();
    transfer_buffer_write = 1'b1;
    @(negedge clock);
    transfer_buffer_write = 1'b0;
    repeat (4) @(negedge clock);
    chk({3'h0, counting}, 4'h1);
    for (i = 0; i < 100 && scl_oe !== 1'b1; i++) @(negedge clock);
    for (n = 0; n < 100 && scl_oe === 1'b1; n++) @(negedge clock);
    chk(4'(n / 2), 4'h9);
    chk({3'h0, n[0]}, 4'h0);
    held = rate_divider_counter;
    clk_en = 1'b0;
    repeat (4) @(negedge clock);
    chk({3'h0, rate_divider_counter == held}, 4'h1);
    clk_en = 1'b1;
    operation_done = 1'b1;
    @(negedge clock);
    operation_done = 1'b0;
    chk({3'h0, counting}, 4'h0);
    transfer_buffer_write = 1'b1;
    @(negedge clock);
    transfer_buffer_write = 1'b0;
    repeat (2) @(negedge clock);
    master_mode = 1'b0;
    @(negedge clock);
    chk({3'h0, counting}, 4'h0);
    master_mode = 1'b1;
    end_of_test();
  end
endmodule
`default_nettype wire

/* rdsc_pkg.sv */
// Package for the serial-clock rate generator and START collision block.
// Assumes one 100 MHz clock with phase ticks supplied by the core.
package rdsc_pkg;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int RDSC_RELOAD_W = 7;
  localparam logic [6:0] RDSC_COUNT_RST = 7'h00;
  localparam logic [6:0] RDSC_RELOAD_RST = 7'h00;
  localparam logic [1:0] RDSC_PHASE_LAST = 2'h3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RDSC_IDLE,
    RDSC_START_CHECK,
    RDSC_START_HOLD,
    RDSC_RUN
  } rdsc_state_t;

  typedef struct packed {
    logic i;
    logic o;
    logic oe;
  } rdsc_pin_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } rdsc_bus_t;

endpackage
